// File: test/nand_bank_controller_sva.sv
// Port-level assertions for the NAND bank controller
`timescale 1ns/100ps
module nand_bank_controller_sva (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Wishbone
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // NAND pins
  input wire logic [1:0] nand_chip_enable_n,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       cmd_latch,
  input wire logic       addr_latch,
  input wire logic [1:0] flash_data_oe
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire ce_low  = ~&nand_chip_enable_n;
  wire st_high = read_strobe_n & write_strobe_n;
  sequence ce_release;
    $rose(&nand_chip_enable_n);
  endsequence
  sequence strobe_fall;
    $fell(st_high);
  endsequence
  sequence strobe_rise;
    $rose(st_high);
  endsequence
  AST_ONE_BANK: assert property (nand_chip_enable_n != 2'b00)
    else $error("both chip enables low");
  AST_STROBE_IN_CE: assert property (!st_high |-> ce_low)
    else $error("strobe low outside chip enable");
  AST_ONE_STROBE: assert property (read_strobe_n | write_strobe_n)
    else $error("both strobes low");
  AST_SETUP: assert property (strobe_fall |-> $past(ce_low))
    else $error("strobe fell without setup");
  AST_HOLD: assert property (strobe_rise |-> ce_low)
    else $error("chip enable rose with strobe");
  AST_ACK_END: assert property (ce_release |-> wb_ack_o)
    else $error("no ack at end");
  AST_CE_GAP: assert property (ce_release |=> !ce_low)
    else $error("chip enable gap short");
  AST_ACK_REQ: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i ##1 !wb_ack_o)
    else $error("ack without request");
  AST_OE_WRITE: assert property (|flash_data_oe |-> ce_low && read_strobe_n)
    else $error("data driven outside write");
  AST_LATCH: assert property ((cmd_latch | addr_latch) |-> ce_low && !(cmd_latch && addr_latch))
    else $error("latch misuse");
endmodule // nand_bank_controller_sva
bind nand_bank_controller nand_bank_controller_sva nand_bank_controller_sva_i (
  .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .nand_chip_enable_n(nand_chip_enable_n),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
  .cmd_latch(cmd_latch), .addr_latch(addr_latch), .flash_data_oe(flash_data_oe));

// File: test/nand_flash_model.sv
// Behavioural NAND flash partner on bank 0
`timescale 1ns/100ps
module nand_flash_model #(
  parameter int BUSY = 20
) (
  // Clock
  input  wire logic        core_clk,
  // Strobes and latches
  input  wire logic        chip_enable_n,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic        cmd_latch,
  input  wire logic        addr_latch,
  // Data bus
  input  wire logic [15:0] flash_data_out,
  input  wire logic [1:0]  flash_data_oe,
  output wire logic [15:0] flash_data_in,
  // Ready/busy, driven high when ready and low while busy
  output wire logic        ready_busy
);
  logic [15:0] mem [0:255];
  logic [15:0] last     = 16'h0000;
  logic [7:0]  ptr      = 8'h00;
  logic [7:0]  last_cmd = 8'h00;
  logic        pw       = 1'b1;
  logic        pr       = 1'b1;
  int          busy     = 0;
  // Undriven lanes show the inverse of the last level
  wire  [15:0] rdv = (!chip_enable_n && !read_strobe_n) ? mem[ptr] : ~last;
  assign flash_data_in[7:0]  = flash_data_oe[0] ? flash_data_out[7:0] : rdv[7:0];
  assign flash_data_in[15:8] = flash_data_oe[1] ? flash_data_out[15:8] : rdv[15:8];
  assign ready_busy = (busy == 0);
  ////////////////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    pw <= write_strobe_n;
    pr <= read_strobe_n;
    last <= flash_data_in;
    if (busy > 0)
      busy <= busy - 1;
    if (write_strobe_n && !pw && !chip_enable_n)
    begin
      if (cmd_latch)
      begin
        last_cmd <= flash_data_in[7:0];
        if (flash_data_in[7:0] == 8'h10)
          busy <= BUSY;
      end
      else if (addr_latch)
        ptr <= flash_data_in[7:0];
      else
      begin
        mem[ptr] <= flash_data_in;
        ptr <= ptr + 8'h01;
      end
    end
    if (read_strobe_n && !pr && !chip_enable_n)
      ptr <= ptr + 8'h01;
  end
endmodule // nand_flash_model

// File: test/tb.sv
// Self-checking bench for the NAND bank controller
`timescale 1ns/100ps
`include "nand_ctrl_map.vh"
module tb;
  logic        core_clk, rst_n, cyc, stb, we, rb0, rb1, rd_n, wr_n, cle, ale, ack;
  logic [19:0] adr;
  logic [31:0] dat, rd, wbo, tcom, tatt, seed, d;
  logic [1:0]  ce_n, oe, irq, oe_acc, oe_cap, ce_acc, ce_cap;
  logic [15:0] fdo, fdi;
  logic [7:0]  ce_cnt, ce_len, st_cnt, st_len, su_cnt, su_len, z_cnt, z_len;
  logic [7:0]  eb [0:7];
  int          fail_count = 0, n_checks = 0, n_acc = 0, slow = 0;
  nand_bank_controller nand_bank_controller_i (.core_clk(core_clk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(wbo), .wb_ack_o(ack), .nand_chip_enable_n(ce_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .cmd_latch(cle), .addr_latch(ale),
    .flash_data_out(fdo), .flash_data_oe(oe), .flash_data_in(fdi), .wait_input_n(rb0),
    .ready_busy_irq_input({rb1, rb0}), .nand_irq(irq));
  nand_flash_model nand_flash_model_i (.core_clk(core_clk), .chip_enable_n(ce_n[0]),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .cmd_latch(cle), .addr_latch(ale),
    .flash_data_out(fdo), .flash_data_oe(oe), .flash_data_in(fdi), .ready_busy(rb0));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////
  // Per-access pin timing monitor
  always @(posedge core_clk)
  begin
    if (&ce_n)
    begin
      if (ce_cnt != 0)
      begin
        {ce_len, st_len, su_len, z_len} <= {ce_cnt, st_cnt, su_cnt, z_cnt};
        {oe_cap, ce_cap} <= {oe_acc, ce_acc};
        n_acc <= n_acc + 1;
      end
      {ce_cnt, st_cnt, su_cnt, z_cnt, oe_acc, ce_acc} <= 0;
    end
    else
    begin
      ce_cnt <= ce_cnt + 1;
      ce_acc <= ce_acc | ~ce_n;
      oe_acc <= oe_acc | oe;
      if (!(rd_n & wr_n))
        st_cnt <= st_cnt + 1;
      else if (st_cnt == 0)
        su_cnt <= su_cnt + 1;
      if (oe_acc == 0 && oe == 0)
        z_cnt <= z_cnt + 1;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [19:0] a, input logic [31:0] v);
    @(posedge core_clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, v};
    do
    begin
      @(posedge core_clk);
    end
    while (ack !== 1'b1);
    rd = wbo;
    chk({31'h0, ack}, 32'h1);
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rio(input logic w, input logic [5:0] o, input logic [31:0] v);
    wb(w, {14'h0000, o}, v);
  endtask
  task automatic mem(input logic w, input logic [19:0] a, input logic [15:0] v);
    logic [31:0] t;
    int          b;
    t = a[17] ? tatt : tcom;
    b = n_acc;
    wb(w, a, {16'h0000, v});
    @(negedge core_clk);
    chk(n_acc - b, 1);
    chk(st_len, t[15:8] + 1);
    if (slow)
      chk(ce_len > t[7:0] + t[15:8] + t[23:16] + 3, 1);
    else
    begin
      chk(ce_len, t[7:0] + t[15:8] + t[23:16] + 3);
      chk(su_len, t[7:0] + 1);
    end
    if (w)
      chk(z_len, t[31:24]);
  endtask
  function automatic logic [31:0] ecc_calc(input int n);
    logic [31:0] r;
    r = 0;
    for (int i = 0; i < n; i++)
      for (int b = 0; b < 8; b++)
        if (eb[i][b])
        begin
          for (int k = 0; k < 3; k++)
            r[2*k+b[k]] ^= 1'b1;
          for (int k = 0; k < 9; k++)
            r[6+2*k+i[k]] ^= 1'b1;
        end
    return r;
  endfunction
  task summarize;
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    int          i, b;
    logic [19:0] bs;
    {cyc, stb, we, adr, dat, rb1, rst_n, seed} = {23'h0, 32'h0, 2'b00, 32'h747d};
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rio(0, `OFS_CTRL, 0);
    chk(rd, `CTRL_RST);
    rio(0, `OFS_TATT + `OFS_BANK_STEP, 0);
    chk(rd, `TIM_RST);
    rio(0, `OFS_STAT, 0);
    chk(rd, {26'h0, `STAT_RST} | 1 << `STAT_LEVEL_FLAG);
    rio(1, 6'h28, 32'hFFFFFFFF);
    rio(0, 6'h28, 0);
    chk(rd, 0);
    // Bank off, then bank on but not NAND: no pin activity
    for (i = 0; i < 2; i++)
    begin
      rio(1, `OFS_CTRL, i ? 32'h00000004 : `CTRL_RST);
      b = n_acc;
      wb(1, 20'h88000, 32'h000000FF);
      wb(0, 20'h80000, 0);
      chk(rd, 0);
      chk(n_acc - b, 0);
    end
    // Random timing words through common and attribute space, 8-bit bus
    for (i = 0; i < 6; i++)
    begin
      tcom = $random(seed) & 32'h01030303 | 32'h100;
      tatt = $random(seed) & 32'h01030303 | 32'h100;
      d = $random(seed);
      bs = {2'b10, i[0], 17'h00000};
      rio(1, `OFS_TCOM, tcom);
      rio(1, `OFS_TATT, tatt);
      rio(1, `OFS_CTRL, 32'h0000000C);
      mem(1, bs | 20'h08000, 16'h0080);
      chk(nand_flash_model_i.last_cmd, 8'h80);
      chk(ce_cap, 2'b01);
      mem(1, bs | 20'h10000, i);
      mem(1, bs, d[15:0]);
      chk(oe_cap, 2'b01);
      mem(1, bs | 20'h10000, i);
      mem(0, bs, 0);
      chk(rd, {24'h0, d[7:0]});
    end
    // 16-bit bus
    rio(1, `OFS_CTRL, 32'h0000001C);
    mem(1, 20'h90000, 16'h0010);
    mem(1, 20'h80000, d[31:16]);
    chk(oe_cap, 2'b11);
    mem(1, 20'h90000, 16'h0010);
    mem(0, 20'h80000, 0);
    chk(rd, {16'h0, d[31:16]});
    // Bank 1 drives only its own chip enable
    rio(1, `OFS_TCOM + `OFS_BANK_STEP, tcom);
    rio(1, `OFS_CTRL + `OFS_BANK_STEP, 32'h0000000C);
    mem(1, 20'hC8000, 16'h00FF);
    chk(ce_cap, 2'b10);
    // Wait feature on: access after a program command waits for ready
    rio(1, `OFS_CTRL, 32'h0000000E);
    mem(1, 20'h88000, 16'h0010);
    slow = 1;
    mem(0, 20'h80000, 0);
    slow = 0;
    rio(1, `OFS_CTRL, 32'h0000000C);
    mem(1, 20'h88000, 16'h0010);
    mem(0, 20'h80000, 0);
    // ECC over a short run of a 512-byte page, then kept after stop
    rio(1, `OFS_CTRL, 32'h0002004C);
    mem(1, 20'h90000, 0);
    for (i = 0; i < 5; i++)
    begin
      eb[i] = $random(seed);
      mem(1, 20'h80000, {8'h00, eb[i]});
    end
    rio(1, `OFS_CTRL, 32'h0002000C);
    rio(0, `OFS_ECC, 0);
    chk(rd, ecc_calc(5));
    mem(1, 20'h80000, 16'h00FF);
    rio(0, `OFS_ECC, 0);
    chk(rd, ecc_calc(5));
    // Ready/busy irq on bank 1: rise, level, fall
    for (i = 0; i < 3; i++)
    begin
      rio(1, `OFS_STAT + `OFS_BANK_STEP, 32'h00000007);
      @(negedge core_clk);
      chk(irq, 2'b00);
      rio(1, `OFS_STAT + `OFS_BANK_STEP, 32'h00000008 << i);
      rb1 <= (i != 2);
      repeat (6) @(posedge core_clk);
      chk(irq, 2'b10);
      rio(0, `OFS_STAT + `OFS_BANK_STEP, 0);
      chk(rd[i], 1'b1);
    end
    summarize;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    summarize;
  end
endmodule // tb

// File: verilog/nand_bank_controller.v
// NAND flash bank controller: Wishbone registers, access sequencer, ready/busy irq, ECC
//
// Overview of operation
// - Two NAND banks, each with its own chip enable pin.
// - A bank makes external accesses only while its enable bit is one.
// - Memory type bit one selects the NAND command/address/data protocol.
// - Width field 00 uses 8 data lines; 16-bit drives upper lines too.
// - ECC page size field 001 selects a 512-byte page.
// - ECC accumulates only while the bank's ECC enable bit is set.
// - With wait enabled, hold new access until ready, chip enable held low.
// - Ready/busy irq on rising edge, falling edge or level, each separately enabled.
// - Chip enable low for (SET+1)+(WAIT+1)+(HOLD+1) cycles per access, plus any cycles spent waiting for ready.
// - Read or write strobe low exactly WAIT+1 cycles per access.
// - On writes data bus floats float-cycles count before being driven.
// - Separate timing sets for common and attribute space.
// - Two independent ECC units, one per bank.
// - ECC pages 256 to 8192 bytes give 22 to 32 bit codes.
// - ECC covers only bytes moved between start and stop.
// - ECC computes Hamming row and column parities over transferred bytes.
// - Command section writes are commands, address section address cycles, data data.
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "nand_ctrl_map.vh"

module nand_bank_controller (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [19:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // NAND strobes and latches
  output reg  [1:0]  nand_chip_enable_n,
  output reg         read_strobe_n,
  output reg         write_strobe_n,
  output reg         cmd_latch,
  output reg         addr_latch,
  // NAND data bus
  output reg  [15:0] flash_data_out,
  output reg  [1:0]  flash_data_oe,
  input  wire [15:0] flash_data_in,
  // Ready/busy
  input  wire        wait_input_n,
  input  wire [1:0]  ready_busy_irq_input,
  output reg  [1:0]  nand_irq
);

  localparam ST_IDLE   = 3'h0;
  localparam ST_READY  = 3'h1;
  localparam ST_SETUP  = 3'h2;
  localparam ST_STROBE = 3'h3;
  localparam ST_HOLD   = 3'h4;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function [7:0] tfield;
    input [31:0] word;
    input [1:0]  idx;
    begin
      tfield = word[idx*8 +: 8];
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0]  sel;
    reg   [31:0] m;
    begin
      m     = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      merge = (old & ~m) | (din & m);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  reg  [31:0] ctrl [0:1];
  reg  [31:0] tcom [0:1];
  reg  [31:0] tatt [0:1];
  reg  [5:0]  stat [0:1];
  reg  [2:0]  state;
  reg  [7:0]  cnt;
  reg  [9:0]  elapsed;
  reg         cur_bank;
  reg         cur_we;
  reg         cur_wide;
  reg  [1:0]  cur_sect;
  reg  [31:0] tim;
  reg  [15:0] rdata;
  reg  [1:0]  ecc_valid;
  reg  [7:0]  ecc_byte;
  reg  [15:0] data_s1;
  reg  [15:0] data_s2;
  reg         wait_s1;
  reg         wait_s2;
  reg  [1:0]  rb_s1;
  reg  [1:0]  rb_s2;
  reg  [1:0]  rb_prev;
  wire [63:0] ecc_flat;
  integer     b;

  wire        idle     = (state == ST_IDLE);
  wire        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & idle;
  wire        mem_req  = req & wb_adr_i[`MEM_SEL_BIT];
  wire        reg_req  = req & ~wb_adr_i[`MEM_SEL_BIT];
  wire        reg_map  = (wb_adr_i[18:6] == 13'h0000);
  wire [5:0]  reg_ofs  = {wb_adr_i[5:3], 3'h0};
  wire        reg_bank = wb_adr_i[2];
  wire        req_bank = wb_adr_i[`BANK_SEL_BIT];
  wire [31:0] req_ctrl = ctrl[req_bank];
  wire [31:0] req_tim  = wb_adr_i[`ATTR_SEL_BIT] ? tatt[req_bank] : tcom[req_bank];
  wire [1:0]  req_sect = wb_adr_i[`SECT_HI:`SECT_LO];
  wire        req_wide = (req_ctrl[`CTRL_WID_HI:`CTRL_WID_LO] == `WID_16BIT);
  wire        req_live = req_ctrl[`CTRL_BANK_EN] & req_ctrl[`CTRL_TYPE];
  wire        req_hold = req_ctrl[`CTRL_WAIT_EN] & ~wait_s2;
  wire [7:0]  t_setup  = tfield(tim, `TIM_SETUP);
  wire [7:0]  t_wait   = tfield(tim, `TIM_WAIT);
  wire [7:0]  t_hold   = tfield(tim, `TIM_HOLD);
  wire [7:0]  t_float  = tfield(tim, `TIM_FLOAT);
  wire        drive_nx = cur_we & ((elapsed + 10'h001) >= {2'h0, t_float});
  wire [15:0] rd_now   = cur_wide ? data_s2 : {8'h00, data_s2[7:0]};

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_s1 <= 16'h0000;
      data_s2 <= 16'h0000;
      wait_s1 <= 1'b1;
      wait_s2 <= 1'b1;
      rb_s1   <= 2'h3;
      rb_s2   <= 2'h3;
      rb_prev <= 2'h3;
    end
    else
    begin
      data_s1 <= flash_data_in;
      data_s2 <= data_s1;
      wait_s1 <= wait_input_n;
      wait_s2 <= wait_s1;
      rb_s1   <= ready_busy_irq_input;
      rb_s2   <= rb_s1;
      rb_prev <= rb_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register file and ready/busy interrupt flags

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (b = 0; b < 2; b = b + 1)
      begin
        ctrl[b] <= `CTRL_RST;
        tcom[b] <= `TIM_RST;
        tatt[b] <= `TIM_RST;
        stat[b] <= `STAT_RST;
      end
      nand_irq <= 2'h0;
    end
    else
    begin
      for (b = 0; b < 2; b = b + 1)
      begin
        if (reg_req && wb_we_i && reg_map && reg_bank == b[0])
        begin
          case (reg_ofs)
            `OFS_CTRL: ctrl[b] <= merge(ctrl[b], wb_dat_i, wb_sel_i);
            `OFS_TCOM: tcom[b] <= merge(tcom[b], wb_dat_i, wb_sel_i);
            `OFS_TATT: tatt[b] <= merge(tatt[b], wb_dat_i, wb_sel_i);
            default: ;
          endcase
        end
        // Edge and level flags: set wins over write-one-to-clear
        stat[b][`STAT_RISE_FLAG] <= (stat[b][`STAT_RISE_FLAG]
          & ~(reg_req & wb_we_i & reg_map & reg_ofs == `OFS_STAT & reg_bank == b[0]
              & wb_sel_i[0] & wb_dat_i[`STAT_RISE_FLAG]))
          | (rb_s2[b] & ~rb_prev[b]);
        stat[b][`STAT_LEVEL_FLAG] <= (stat[b][`STAT_LEVEL_FLAG]
          & ~(reg_req & wb_we_i & reg_map & reg_ofs == `OFS_STAT & reg_bank == b[0]
              & wb_sel_i[0] & wb_dat_i[`STAT_LEVEL_FLAG]))
          | rb_s2[b];
        stat[b][`STAT_FALL_FLAG] <= (stat[b][`STAT_FALL_FLAG]
          & ~(reg_req & wb_we_i & reg_map & reg_ofs == `OFS_STAT & reg_bank == b[0]
              & wb_sel_i[0] & wb_dat_i[`STAT_FALL_FLAG]))
          | (~rb_s2[b] & rb_prev[b]);
        if (reg_req && wb_we_i && reg_map && reg_ofs == `OFS_STAT && reg_bank == b[0]
            && wb_sel_i[0])
          stat[b][`STAT_FALL_EN:`STAT_RISE_EN] <= wb_dat_i[`STAT_FALL_EN:`STAT_RISE_EN];
        nand_irq[b] <= |(stat[b][`STAT_FALL_FLAG:`STAT_RISE_FLAG]
          & {stat[b][`STAT_FALL_EN], stat[b][`STAT_LEVEL_EN], stat[b][`STAT_RISE_EN]});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer and external access sequencer

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state              <= ST_IDLE;
      cnt                <= 8'h00;
      elapsed            <= 10'h000;
      cur_bank           <= 1'b0;
      cur_we             <= 1'b0;
      cur_wide           <= 1'b0;
      cur_sect           <= `SECT_DATA;
      tim                <= `TIM_RST;
      rdata              <= 16'h0000;
      ecc_valid          <= 2'h0;
      ecc_byte           <= 8'h00;
      wb_ack_o           <= 1'b0;
      wb_dat_o           <= 32'h00000000;
      nand_chip_enable_n <= 2'h3;
      read_strobe_n      <= 1'b1;
      write_strobe_n     <= 1'b1;
      cmd_latch          <= 1'b0;
      addr_latch         <= 1'b0;
      flash_data_out     <= 16'h0000;
      flash_data_oe      <= 2'h0;
    end
    else
    begin
      wb_ack_o  <= 1'b0;
      ecc_valid <= 2'h0;
      case (state)
        ST_IDLE:
        begin
          if (reg_req)
          begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= 32'h00000000;
            if (reg_map)
            begin
              case (reg_ofs)
                `OFS_CTRL: wb_dat_o <= ctrl[reg_bank];
                `OFS_STAT: wb_dat_o <= {26'h0000000, stat[reg_bank]};
                `OFS_TCOM: wb_dat_o <= tcom[reg_bank];
                `OFS_TATT: wb_dat_o <= tatt[reg_bank];
                `OFS_ECC:  wb_dat_o <= ecc_flat[reg_bank*32 +: 32];
                default:   wb_dat_o <= 32'h00000000;
              endcase
            end
          end
          else if (mem_req && !req_live)
          begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= 32'h00000000;
          end
          else if (mem_req)
          begin
            cur_bank                     <= req_bank;
            cur_we                       <= wb_we_i;
            cur_wide                     <= req_wide;
            cur_sect                     <= req_sect;
            tim                          <= req_tim;
            nand_chip_enable_n[req_bank] <= 1'b0;
            cmd_latch                    <= (req_sect == `SECT_CMD);
            addr_latch                   <= (req_sect == `SECT_ADDR);
            flash_data_out               <= req_wide ? wb_dat_i[15:0]
                                                     : {8'h00, wb_dat_i[7:0]};
            cnt                          <= 8'h00;
            elapsed                      <= 10'h000;
            if (req_hold)
              state <= ST_READY;
            else
            begin
              state         <= ST_SETUP;
              flash_data_oe <= (wb_we_i && tfield(req_tim, `TIM_FLOAT) == 8'h00)
                               ? {req_wide, 1'b1} : 2'h0;
            end
          end
        end
        ST_READY:
        begin
          // Chip enable stays low while the part reports busy
          if (wait_s2)
          begin
            state         <= ST_SETUP;
            flash_data_oe <= (cur_we && t_float == 8'h00) ? {cur_wide, 1'b1} : 2'h0;
          end
        end
        ST_SETUP:
        begin
          elapsed       <= elapsed + 10'h001;
          flash_data_oe <= drive_nx ? {cur_wide, 1'b1} : 2'h0;
          if (cnt == t_setup)
          begin
            state          <= ST_STROBE;
            cnt            <= 8'h00;
            read_strobe_n  <= cur_we;
            write_strobe_n <= ~cur_we;
          end
          else
            cnt <= cnt + 8'h01;
        end
        ST_STROBE:
        begin
          elapsed       <= elapsed + 10'h001;
          flash_data_oe <= drive_nx ? {cur_wide, 1'b1} : 2'h0;
          if (cnt == t_wait)
          begin
            state          <= ST_HOLD;
            cnt            <= 8'h00;
            read_strobe_n  <= 1'b1;
            write_strobe_n <= 1'b1;
          end
          else
            cnt <= cnt + 8'h01;
        end
        ST_HOLD:
        begin
          elapsed       <= elapsed + 10'h001;
          flash_data_oe <= drive_nx ? {cur_wide, 1'b1} : 2'h0;
          // Synchronised bus now shows the sample taken one clock before the strobe rose
          if (cnt == 8'h00 && !cur_we)
            rdata <= rd_now;
          if (cnt == t_hold)
          begin
            state              <= ST_IDLE;
            cnt                <= 8'h00;
            nand_chip_enable_n <= 2'h3;
            cmd_latch          <= 1'b0;
            addr_latch         <= 1'b0;
            flash_data_oe      <= 2'h0;
            wb_ack_o           <= 1'b1;
            wb_dat_o           <= cur_we ? 32'h00000000
                                         : {16'h0000, (cnt == 8'h00) ? rd_now : rdata};
            if (cur_sect == `SECT_DATA)
            begin
              ecc_valid[cur_bank] <= 1'b1;
              ecc_byte            <= cur_we ? flash_data_out[7:0]
                                            : ((cnt == 8'h00) ? rd_now[7:0] : rdata[7:0]);
            end
          end
          else
            cnt <= cnt + 8'h01;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One ECC engine per bank

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_ecc
      nand_ecc_unit u_ecc (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .enable     (ctrl[g][`CTRL_ECC_EN]),
        .page_size  (ctrl[g][`CTRL_ECC_PAGE_SIZE_FIELD_HI:`CTRL_ECC_PAGE_SIZE_FIELD_LO]),
        .byte_valid (ecc_valid[g]),
        .byte_data  (ecc_byte),
        .ecc_code   (ecc_flat[g*32 +: 32])
      );
    end
  endgenerate

endmodule // nand_bank_controller

// File: verilog/nand_ctrl_map.vh
// Register offsets, field positions, reset values and decode bits of the NAND bank controller
`ifndef NAND_CTRL_MAP_VH
`define NAND_CTRL_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets, bank 0 at the offset, bank 1 at offset plus 4
`define OFS_CTRL      6'h00
`define OFS_STAT      6'h08
`define OFS_TCOM      6'h10
`define OFS_TATT      6'h18
`define OFS_ECC       6'h20
`define OFS_BANK_STEP 6'h04

////////////////////////////////////////////////////////////////////////////////
// Bank control word fields
`define CTRL_WAIT_EN   1
`define CTRL_BANK_EN   2
`define CTRL_TYPE      3
`define CTRL_WID_LO    4
`define CTRL_WID_HI    5
`define CTRL_ECC_EN    6
`define CTRL_ECC_PAGE_SIZE_FIELD_LO  17
`define CTRL_ECC_PAGE_SIZE_FIELD_HI  19
`define WID_8BIT       2'h0
`define WID_16BIT      2'h1

////////////////////////////////////////////////////////////////////////////////
// Bank irq status word fields
`define STAT_RISE_FLAG  0
`define STAT_LEVEL_FLAG 1
`define STAT_FALL_FLAG  2
`define STAT_RISE_EN    3
`define STAT_LEVEL_EN   4
`define STAT_FALL_EN    5

////////////////////////////////////////////////////////////////////////////////
// Timing word byte fields
`define TIM_SETUP 2'h0
`define TIM_WAIT  2'h1
`define TIM_HOLD  2'h2
`define TIM_FLOAT 2'h3

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define CTRL_RST 32'h00000018
`define STAT_RST 6'h00
`define TIM_RST  32'hFCFCFCFC

////////////////////////////////////////////////////////////////////////////////
// Memory window decode
`define MEM_SEL_BIT  19
`define BANK_SEL_BIT 18
`define ATTR_SEL_BIT 17
`define SECT_HI      16
`define SECT_LO      15
`define SECT_DATA    2'h0
`define SECT_CMD     2'h1
`define SECT_ADDR    2'h2

////////////////////////////////////////////////////////////////////////////////
// ECC sizing
`define ECC_MIN_PAGE  14'h0100
`define ECC_MIN_WIDTH 6'h16

`endif

// File: verilog/nand_ecc_unit.v
// Hamming row and column parity engine for one NAND bank
`timescale 1ns/100ps
`include "nand_ctrl_map.vh"

module nand_ecc_unit (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Control
  input  wire        enable,
  input  wire [2:0]  page_size,
  // Byte stream
  input  wire        byte_valid,
  input  wire [7:0]  byte_data,
  // Result
  output reg  [31:0] ecc_code
);

  reg         run;
  reg  [13:0] count;
  reg  [5:0]  col;
  reg  [25:0] row;
  wire [13:0] page_bytes;
  wire        live;
  wire        bpar;
  wire [5:0]  code_width;
  wire [5:0]  next_col;
  wire [25:0] next_row;

  assign page_bytes = `ECC_MIN_PAGE << page_size;
  assign live       = run & byte_valid & (count < page_bytes);
  assign bpar       = ^byte_data;
  assign code_width = `ECC_MIN_WIDTH + {2'h0, page_size, 1'b0};

  // Column parities, complement first in each pair
  assign next_col[0] = col[0] ^ (^{byte_data[6], byte_data[4], byte_data[2], byte_data[0]});
  assign next_col[1] = col[1] ^ (^{byte_data[7], byte_data[5], byte_data[3], byte_data[1]});
  assign next_col[2] = col[2] ^ (^{byte_data[5], byte_data[4], byte_data[1], byte_data[0]});
  assign next_col[3] = col[3] ^ (^{byte_data[7], byte_data[6], byte_data[3], byte_data[2]});
  assign next_col[4] = col[4] ^ (^byte_data[3:0]);
  assign next_col[5] = col[5] ^ (^byte_data[7:4]);

  // Row parities by byte address bit
  genvar j;
  generate
    for (j = 0; j < 13; j = j + 1)
    begin : g_row
      assign next_row[2*j]   = row[2*j]   ^ (bpar & ~count[j]);
      assign next_row[2*j+1] = row[2*j+1] ^ (bpar &  count[j]);
    end
  endgenerate

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run      <= 1'b0;
      count    <= 14'h0000;
      col      <= 6'h00;
      row      <= 26'h0000000;
      ecc_code <= 32'h00000000;
    end
    else if (enable && !run)
    begin
      run      <= 1'b1;
      count    <= 14'h0000;
      col      <= 6'h00;
      row      <= 26'h0000000;
      ecc_code <= 32'h00000000;
    end
    else if (!enable && run)
    begin
      run      <= 1'b0;
      ecc_code <= {row, col} & ~(32'hFFFFFFFF << code_width);
    end
    else if (live)
    begin
      count <= count + 14'h0001;
      col   <= next_col;
      row   <= next_row;
    end
  end

endmodule // nand_ecc_unit
